// *** design/bfp_pkg.sv ***
package bfp_pkg;

    // clock rate, used to turn every time figure into a cycle count
    localparam int CLK_MHZ = 25;

    // delay figures in microseconds (typical values)
    localparam int SC_DLY_US = 300;
    localparam int OC_DET_US = 10000;
    localparam int OC_REL_US = 1000;
    localparam int XC_DET_US = 1000;
    localparam int XC_REL_US = 1500;

    // test mode divides counter delays by two to this power
    localparam int TEST_SHIFT = 6;

    // width of each delay counter
    localparam int CNT_W = 24;

    // timer channels of the shared delay block
    localparam int NT = 5;
    localparam int T_SC = 0;
    localparam int T_OC_DET = 1;
    localparam int T_OC_REL = 2;
    localparam int T_XC_DET = 3;
    localparam int T_XC_REL = 4;

    // bit positions of the synchronised input vector
    localparam int NIN = 8;
    localparam int I_SC = 0;
    localparam int I_OC = 1;
    localparam int I_XC = 2;
    localparam int I_OVC = 3;
    localparam int I_OVD = 4;
    localparam int I_ZCELL = 5;
    localparam int I_ZOK = 6;
    localparam int I_TEST = 7;

    // discharge side states
    typedef enum logic [1:0] {
        DS_NORMAL,
        DS_OVD,
        DS_OC,
        DS_SC
    } bfp_dstate_t;

    // charge side states
    typedef enum logic {
        CS_NORMAL,
        CS_XC
    } bfp_cstate_t;

endpackage

// *** design/bfp_delay_if.sv ***
`timescale 1ns/10ps
interface bfp_delay_if #(
    parameter int N = 5,
    parameter int W = 24
);
    // per channel: run level, target count, expiry level
    logic [N-1:0] run;
    logic [N-1:0][W-1:0] limit;
    logic [N-1:0] done;

    modport ctl (
        output run,
        output limit,
        input done
    );

    modport tmr (
        input run,
        input limit,
        output done
    );
endinterface // bfp_delay_if

// *** design/bfp_delay.sv ***
`timescale 1ns/10ps
module bfp_delay #(
    parameter int N = 5,
    parameter int W = 24
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // timer channels
    bfp_delay_if.tmr tif
);

    // one saturating counter per channel, cleared whenever its run level drops
    for (genvar i = 0; i < N; i++) begin : g_chan
        logic [W-1:0] cnt_r;
        always_ff @(posedge sys_clk) begin
            if (rst || !tif.run[i]) begin
                cnt_r <= '0;
            end else if (cnt_r < tif.limit[i]) begin
                cnt_r <= cnt_r + 1'h1;
            end
        end
        // compare with >= so a limit lowered mid-count still expires
        assign tif.done[i] = tif.run[i] && (cnt_r >= tif.limit[i]);
    end

endmodule // bfp_delay

// *** design/bfp_fsm.sv ***
`timescale 1ns/10ps
// Summary of operation
// - sense at short threshold enters short state after short delay, below over-current delay
// - short state turns discharge gate low, same as over-current
// - after short, sense pull-down on and no standby
// - over-current or short releases after release delay once sense at or below threshold
// - sense at or below charger threshold drops charge gate after detect delay
// - charger condition vanishing during detect delay abandons detection
// - in charger state, sense recovering raises charge gate after release delay
// - no charger detection while discharge gate is low
// - charger delay starts only once discharge gate is high again
// - with zero-volt cells, charge gate rises once charge voltage is enough
// - test input high shortens counter delays; low gives normal delays
// - short-circuit delay is not counter derived and ignores test input
// - over-charge wins over over-discharge; over-discharge resumes afterwards
// - over-charge first releases both pulls; later over-discharge adds pull-up, no standby
// - no standby while over-charge then over-discharge overlap lasts
// - over-discharge drops discharge gate, enters standby, pulls sense up
// - over-current drops discharge gate after delay, pulls sense down, no standby
// - over-charge suppresses over-current detection, short detection stays active
module bfp_fsm
    import bfp_pkg::*;
#(
    parameter int SC_DLY_CYC = bfp_pkg::SC_DLY_US * bfp_pkg::CLK_MHZ,
    parameter int OC_DET_CYC = bfp_pkg::OC_DET_US * bfp_pkg::CLK_MHZ,
    parameter int OC_REL_CYC = bfp_pkg::OC_REL_US * bfp_pkg::CLK_MHZ,
    parameter int XC_DET_CYC = bfp_pkg::XC_DET_US * bfp_pkg::CLK_MHZ,
    parameter int XC_REL_CYC = bfp_pkg::XC_REL_US * bfp_pkg::CLK_MHZ
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // comparator results on the sense node
    input wire logic sc_cmp,
    input wire logic oc_cmp,
    input wire logic xc_cmp,
    // cell monitor results
    input wire logic ovc_state,
    input wire logic ovd_cond,
    input wire logic zero_cell,
    input wire logic zchg_ok,
    // delay shortening pin
    input wire logic shorten_pin,
    // gate drives
    output logic dout_gate,
    output logic cout_gate,
    // sense node pull control
    output logic pull_dn_en,
    output logic pull_up_en,
    // low power indication
    output logic standby
);
    import bfp_pkg::*;

    // raw input vector, gathered so one synchroniser serves all pins
    logic [NIN-1:0] pin_raw;
    assign pin_raw[I_SC] = sc_cmp;
    assign pin_raw[I_OC] = oc_cmp;
    assign pin_raw[I_XC] = xc_cmp;
    assign pin_raw[I_OVC] = ovc_state;
    assign pin_raw[I_OVD] = ovd_cond;
    assign pin_raw[I_ZCELL] = zero_cell;
    assign pin_raw[I_ZOK] = zchg_ok;
    assign pin_raw[I_TEST] = shorten_pin;

    // three stage synchroniser; first stage feeds only the second
    // pulses under two cycles may be lost; every input here is a held level
    logic [NIN-1:0] sync1_r;
    logic [NIN-1:0] sync2_r;
    logic [NIN-1:0] sync3_r;
    logic [NIN-1:0] in_q_r;
    logic [NIN-1:0] in_agree;

    // a change is taken once stages two and three agree
    assign in_agree = ~(sync2_r ^ sync3_r);

    // sample every pin on the internal clock
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
            in_q_r <= '0;
        end else begin
            sync1_r <= pin_raw;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            in_q_r <= (in_agree & sync3_r) | (~in_agree & in_q_r);
        end
    end

    // named views of the filtered inputs
    logic sc_q;
    logic oc_q;
    logic xc_q;
    logic ovc_q;
    logic ovd_q;
    logic zcell_q;
    logic zok_q;
    logic test_q;
    assign sc_q = in_q_r[I_SC];
    assign oc_q = in_q_r[I_OC];
    assign xc_q = in_q_r[I_XC];
    assign ovc_q = in_q_r[I_OVC];
    assign ovd_q = in_q_r[I_OVD];
    assign zcell_q = in_q_r[I_ZCELL];
    assign zok_q = in_q_r[I_ZOK];
    assign test_q = in_q_r[I_TEST];

    // state and output registers
    bfp_dstate_t ds_r;
    bfp_dstate_t ds_nxt;
    bfp_cstate_t cs_r;
    bfp_cstate_t cs_nxt;
    logic dout_r;
    logic dout_nxt;
    logic cout_r;
    logic cout_nxt;
    logic pdn_r;
    logic pdn_nxt;
    logic pup_r;
    logic pup_nxt;
    logic stby_r;
    logic stby_nxt;

    // shared delay counters
    bfp_delay_if #(.N(NT), .W(CNT_W)) tif ();

    bfp_delay #(
        .N(NT),
        .W(CNT_W)
    ) u_delay (
        .sys_clk(sys_clk),
        .rst(rst),
        .tif(tif)
    );

    // normal targets; kept as one array so the limit select is one loop
    // the default counts fit the counter width, so the casts drop nothing
    logic [NT-1:0][CNT_W-1:0] norm_lim;
    assign norm_lim[T_SC] = CNT_W'(SC_DLY_CYC);
    assign norm_lim[T_OC_DET] = CNT_W'(OC_DET_CYC);
    assign norm_lim[T_OC_REL] = CNT_W'(OC_REL_CYC);
    assign norm_lim[T_XC_DET] = CNT_W'(XC_DET_CYC);
    assign norm_lim[T_XC_REL] = CNT_W'(XC_REL_CYC);

    // test mode cuts counter delays, never below one cycle
    // one shared shift trades delay accuracy for fast test runs
    for (genvar i = 0; i < NT; i++) begin : g_lim
        logic [CNT_W-1:0] cut_lim;
        logic [CNT_W-1:0] short_lim;
        assign cut_lim = norm_lim[i] >> TEST_SHIFT;
        assign short_lim = (cut_lim == '0) ? CNT_W'(1) : cut_lim;
        if (i == T_SC) begin : g_fixed
            // short delay is not counter derived, test pin has no say
            assign tif.limit[i] = norm_lim[i];
        end else begin : g_cut
            assign tif.limit[i] = test_q ? short_lim : norm_lim[i];
        end
    end

    // discharge side conditions
    logic overlap;
    logic ovd_take;
    logic oc_allow;
    logic in_fault;

    // over-charge first: over-discharge is held back while both hold
    assign overlap = ovc_q && ovd_q;
    assign ovd_take = ovd_q && !ovc_q;
    // over-charge blocks over-current but not short detection
    assign oc_allow = oc_q && !ovc_q;
    assign in_fault = (ds_r == DS_OC) || (ds_r == DS_SC);

    // delay run levels; any drop clears its counter
    // short timer also runs in the over-current state, so a short still escalates
    assign tif.run[T_SC] = sc_q && (ds_r == DS_NORMAL || ds_r == DS_OC);
    assign tif.run[T_OC_DET] = oc_allow && (ds_r == DS_NORMAL);
    // release times the sense node staying at or below the over-current level
    assign tif.run[T_OC_REL] = in_fault && !oc_q;
    // charger detect only with discharge gate high, so the wait starts after it rises
    assign tif.run[T_XC_DET] = (cs_r == CS_NORMAL) && xc_q && dout_r;
    // charger release is timed only inside the charger state
    assign tif.run[T_XC_REL] = (cs_r == CS_XC) && !xc_q;

    // discharge state machine
    always_comb begin
        ds_nxt = ds_r;
        case (ds_r)
            DS_NORMAL: begin
                if (ovd_take) begin
                    ds_nxt = DS_OVD;
                end else if (tif.done[T_SC]) begin
                    ds_nxt = DS_SC;
                end else if (tif.done[T_OC_DET]) begin
                    ds_nxt = DS_OC;
                end
            end
            DS_OVD: begin
                // release delay lives with the cell monitor, not here
                if (!ovd_q) begin
                    ds_nxt = DS_NORMAL;
                end
            end
            DS_OC: begin
                // over-discharge overrides a current fault: pull-up replaces pull-down
                if (ovd_take) begin
                    ds_nxt = DS_OVD;
                end else if (tif.done[T_SC]) begin
                    ds_nxt = DS_SC;
                end else if (tif.done[T_OC_REL]) begin
                    ds_nxt = DS_NORMAL;
                end
            end
            DS_SC: begin
                // a short leaves through the shared over-current release, or to over-discharge
                if (ovd_take) begin
                    ds_nxt = DS_OVD;
                end else if (tif.done[T_OC_REL]) begin
                    ds_nxt = DS_NORMAL;
                end
            end
            default: begin
                ds_nxt = DS_NORMAL;
            end
        endcase
    end

    // charge state machine
    always_comb begin
        cs_nxt = cs_r;
        case (cs_r)
            CS_NORMAL: begin
                if (tif.done[T_XC_DET]) begin
                    cs_nxt = CS_XC;
                end
            end
            CS_XC: begin
                if (tif.done[T_XC_REL]) begin
                    cs_nxt = CS_NORMAL;
                end
            end
            default: begin
                cs_nxt = CS_NORMAL;
            end
        endcase
    end

    // discharge gate is high only in the normal state
    assign dout_nxt = (ds_nxt == DS_NORMAL);

    // over-charge holds the charge gate low for as long as its state is reported
    // zero-volt cells override the normal charge gate logic
    assign cout_nxt = zcell_q ? zok_q : (!ovc_q && cs_nxt == CS_NORMAL);

    // the two pulls come from disjoint states, so they are never on together
    // pull-down after over-current or short
    assign pdn_nxt = (ds_nxt == DS_OC) || (ds_nxt == DS_SC);

    // pull-up after over-discharge, also during the over-charge overlap in the normal state
    assign pup_nxt = (ds_nxt == DS_OVD) || ((ds_nxt == DS_NORMAL) && overlap);

    // standby only in the over-discharge state; an overlap begun by over-charge never reaches it
    assign stby_nxt = (ds_nxt == DS_OVD);

    // state update; outputs register with their state so they never glitch
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ds_r <= DS_NORMAL;
            cs_r <= CS_NORMAL;
        end else begin
            ds_r <= ds_nxt;
            cs_r <= cs_nxt;
        end
    end

    // output registers; gates come up high so the pack is usable after reset
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dout_r <= 1'h1;
            cout_r <= 1'h1;
            pdn_r <= 1'h0;
            pup_r <= 1'h0;
            stby_r <= 1'h0;
        end else begin
            dout_r <= dout_nxt;
            cout_r <= cout_nxt;
            pdn_r <= pdn_nxt;
            pup_r <= pup_nxt;
            stby_r <= stby_nxt;
        end
    end

    // outputs straight from flops
    assign dout_gate = dout_r;
    assign cout_gate = cout_r;
    assign pull_dn_en = pdn_r;
    assign pull_up_en = pup_r;
    assign standby = stby_r;

endmodule // bfp_fsm

// *** testbench/bfp_fsm_checker.sv ***
`timescale 1ns/10ps
module bfp_fsm_checker #(
    parameter int SC_DLY_CYC = 20,
    parameter int OC_REL_CYC = 30
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // watched inputs
    input wire logic sc_cmp,
    input wire logic oc_cmp,
    input wire logic ovc_state,
    input wire logic zero_cell,
    input wire logic zchg_ok,
    input wire logic shorten_pin,
    // watched outputs
    input wire logic dout_gate,
    input wire logic cout_gate,
    input wire logic pull_dn_en,
    input wire logic pull_up_en,
    input wire logic standby
);
    logic [23:0] sc_run_r;
    logic [23:0] rel_run_r;
    logic [23:0] zok_run_r;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // run lengths of raw pin levels; saturate so a long idle never wraps
    always_ff @(posedge sys_clk) begin
        sc_run_r <= (rst || !sc_cmp) ? 24'h0 : sc_run_r + {23'h0, ~&sc_run_r};
        rel_run_r <= (rst || sc_cmp || oc_cmp) ? 24'h0 : rel_run_r + {23'h0, ~&rel_run_r};
        zok_run_r <= (rst || !(zero_cell && zchg_ok)) ? 24'h0 : zok_run_r + {23'h0, ~&zok_run_r};
    end
    a_reset_vals: assert property ($fell(rst) |-> dout_gate && cout_gate && !pull_dn_en
        && !pull_up_en && !standby) else $error("outputs not at reset values");
    a_low_has_pull: assert property (!dout_gate |-> pull_dn_en ^ pull_up_en)
        else $error("discharge gate low without one sense pull");
    a_pulls_exclusive: assert property (!(pull_dn_en && pull_up_en))
        else $error("both sense pulls on");
    a_no_standby_pd: assert property (pull_dn_en |-> !standby)
        else $error("standby during short or over-current");
    a_standby_pull_up: assert property (standby |-> pull_up_en && !dout_gate)
        else $error("standby without pull-up and gate off");
    a_xc_dout_high: assert property (
        $fell(cout_gate) && !ovc_state && !zero_cell |-> dout_gate)
        else $error("charger detect while discharge gate low");
    a_sc_min_delay: assert property (
        $fell(dout_gate) && sc_cmp |-> sc_run_r >= SC_DLY_CYC)
        else $error("short detected before its delay");
    a_oc_rel_delay: assert property (
        $rose(dout_gate) && $past(pull_dn_en) && !shorten_pin |-> rel_run_r >= OC_REL_CYC)
        else $error("early over-current release");
    a_zero_cell_chg: assert property (zok_run_r >= 24'h6 |-> cout_gate)
        else $error("charge gate low with zero-volt charging allowed");
endmodule // bfp_fsm_checker

bind bfp_fsm bfp_fsm_checker #(.SC_DLY_CYC(SC_DLY_CYC), .OC_REL_CYC(OC_REL_CYC))
    bfp_fsm_checker_inst (.sys_clk(sys_clk), .rst(rst), .sc_cmp(sc_cmp), .oc_cmp(oc_cmp),
    .ovc_state(ovc_state), .zero_cell(zero_cell), .zchg_ok(zchg_ok), .shorten_pin(shorten_pin),
    .dout_gate(dout_gate), .cout_gate(cout_gate), .pull_dn_en(pull_dn_en),
    .pull_up_en(pull_up_en), .standby(standby));

// *** testbench/bfp_switch_model.sv ***
`timescale 1ns/10ps
module bfp_switch_model (
    // gate drives
    input wire logic dout_gate,
    input wire logic cout_gate,
    // switch conduction
    output logic dis_on,
    output logic chg_on
);
    // n-channel switches follow the gate; an unknown gate stays unknown, never on
    assign dis_on = dout_gate;
    assign chg_on = cout_gate;
endmodule // bfp_switch_model

// *** testbench/test_battery_fault_protection_fsm.sv ***
`timescale 1ns/10ps
module test_battery_fault_protection_fsm;
    import bfp_pkg::*;
    localparam int SC = 20, OCD = 40, OCR = 30, XCD = 30, XCR = 30;
    localparam logic [4:0] N = 5'h18, OC = 5'h0c, XC = 5'h10, OVD = 5'h0b;
    logic sys_clk = 1'h0;
    logic rst = 1'h1;
    logic sc_cmp = 1'h0, oc_cmp = 1'h0, xc_cmp = 1'h0, ovc_state = 1'h0, ovd_cond = 1'h0;
    logic zero_cell = 1'h0, zchg_ok = 1'h0, shorten_pin = 1'h0;
    logic dout_gate, cout_gate, pull_dn_en, pull_up_en, standby, dis_on, chg_on;
    logic [4:0] exp_q[$];
    int miscompares = 0;
    int checks_done = 0;
    always #20 sys_clk = ~sys_clk;
    bfp_fsm #(.SC_DLY_CYC(SC), .OC_DET_CYC(OCD), .OC_REL_CYC(OCR), .XC_DET_CYC(XCD),
        .XC_REL_CYC(XCR)) bfp_fsm_inst (.sys_clk(sys_clk), .rst(rst), .sc_cmp(sc_cmp),
        .oc_cmp(oc_cmp), .xc_cmp(xc_cmp), .ovc_state(ovc_state), .ovd_cond(ovd_cond),
        .zero_cell(zero_cell), .zchg_ok(zchg_ok), .shorten_pin(shorten_pin),
        .dout_gate(dout_gate), .cout_gate(cout_gate), .pull_dn_en(pull_dn_en),
        .pull_up_en(pull_up_en), .standby(standby));
    bfp_switch_model bfp_switch_model_inst (.dout_gate(dout_gate), .cout_gate(cout_gate),
        .dis_on(dis_on), .chg_on(chg_on));
    // oldest note is compared mid-cycle, when registered outputs are settled
    always @(negedge sys_clk) begin
        while (exp_q.size() > 0) begin
            checks_done++;
            if ({dis_on, chg_on, pull_dn_en, pull_up_en, standby} !== exp_q[0]) begin
                miscompares++;
                $display("[FAIL] %0t: outputs %b, expected %b", $time,
                    {dis_on, chg_on, pull_dn_en, pull_up_en, standby}, exp_q[0]);
            end
            void'(exp_q.pop_front());
        end
    end
    task automatic finish_test();
        if (miscompares == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // note just after an edge so the monitor sees it at the next falling edge
    task automatic note(input logic [4:0] e);
        @(posedge sys_clk);
        #1;
        exp_q.push_back(e);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // sync and output stages add about five cycles, so probe at d and at d+8
    task automatic step(input int d, input logic [4:0] pre, input logic [4:0] post);
        cyc(d - 1);
        note(pre);
        cyc(8);
        note(post);
        cyc(1);
    endtask
    // run is a few hundred cycles; this cap only catches a hang
    initial begin
        #100000;
        miscompares++;
        finish_test();
    end
    initial begin
        void'($urandom(51));
        cyc(4);
        rst = 1'h0;
        note(N);
        cyc(1);
        // over-current detect and release
        oc_cmp = 1'h1;
        step(OCD, N, OC);
        oc_cmp = 1'h0;
        step(OCR, OC, N);
        // short trips ahead of the longer over-current delay
        sc_cmp = 1'h1;
        oc_cmp = 1'h1;
        step(SC, N, OC);
        sc_cmp = 1'h0;
        oc_cmp = 1'h0;
        step(OCR, OC, N);
        // charger pulse shorter than its delay is dropped; the next step proves the restart
        xc_cmp = 1'h1;
        cyc(5 + $urandom_range(XCD - 12));
        xc_cmp = 1'h0;
        cyc(XCD + 10);
        note(N);
        cyc(1);
        xc_cmp = 1'h1;
        step(XCD, N, XC);
        xc_cmp = 1'h0;
        step(XCR, XC, N);
        // charger held through over-discharge is timed only once the gate is back up
        ovd_cond = 1'h1;
        xc_cmp = 1'h1;
        step(1, N, OVD);
        cyc(XCD + 10);
        note(OVD);
        cyc(1);
        ovd_cond = 1'h0;
        step(XCD, N, XC);
        xc_cmp = 1'h0;
        step(XCR, XC, N);
        // over-charge first, then over-discharge: pull-up but no standby
        ovc_state = 1'h1;
        cyc(10);
        note(5'h10);
        cyc(1);
        ovd_cond = 1'h1;
        cyc(10);
        note(5'h12);
        cyc(1);
        ovc_state = 1'h0;
        cyc(10);
        note(OVD);
        cyc(1);
        ovd_cond = 1'h0;
        cyc(10);
        note(N);
        cyc(1);
        // over-charge masks over-current; a short still trips at its full delay
        ovc_state = 1'h1;
        oc_cmp = 1'h1;
        cyc(OCD + 10);
        note(5'h10);
        cyc(1);
        sc_cmp = 1'h1;
        shorten_pin = 1'h1;
        step(SC, 5'h10, 5'h04);
        sc_cmp = 1'h0;
        oc_cmp = 1'h0;
        ovc_state = 1'h0;
        shorten_pin = 1'h0;
        step(OCR, OC, N);
        // test pin high here shortens the over-current delays; boards keep it grounded
        shorten_pin = 1'h1;
        oc_cmp = 1'h1;
        step(1, N, OC);
        oc_cmp = 1'h0;
        step(1, OC, N);
        shorten_pin = 1'h0;
        // zero-volt cells: the charge gate follows the charge-voltage check
        zero_cell = 1'h1;
        for (int i = 0; i < 4; i++) begin
            zchg_ok = (i < 2) ? i[0] : 1'($urandom_range(1));
            cyc(10);
            note({1'h1, zchg_ok, 3'h0});
            cyc(1);
        end
        zero_cell = 1'h0;
        zchg_ok = 1'h0;
        cyc(10);
        note(N);
        cyc(2);
        finish_test();
    end
endmodule // test_battery_fault_protection_fsm
